// *** fks_flash_device.sv ***
// Flash array with key unlock, write and erase sequencing and core stall
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Programming only clears bits to zero
// - Erase sets whole 512-byte page to 0xFF
// - Operations timed internally to completion
// - Core stalled while write or erase runs
// - Keys 0xA5 then 0xF1 unlock flash
// - Wrong key or order disables until reset
// - Operation before unlock disables until reset
// - Each finished operation locks flash again
// - Write enable routes writes to flash
// - Erase: unlock, enables, write into page
// - Block select chooses single or pair
// - Pair program takes single-byte time
// - Single mode: one program per write
// - Pair held, programmed after odd write
// - Requester writes even then odd byte
// - Requester re-keys before each pair byte
// - Requester sets read time above 25 MHz
// - Top 1024 bytes reserved, not usable
// - Requester masks interrupts during sequence
// - Key register reads unlock state code
// - Illegal address access requests error reset
module fks_flash_device import fks_pkg::*; #(
  parameter int FLASH_SIZE = FLASH_BYTES,
  parameter int PROGRAM_COUNT = WRITE_CYCLES,
  parameter int ERASE_COUNT = ERASE_CYCLES
) (
  // Clock, reset and enable
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clockEnable,
  // Link to the core
  fks_link_if.device link,
  // External data RAM write path
  output logic xramWrite,
  output logic [ADDR_W-1:0] xramAddr,
  output logic [7:0] xramData,
  // Flash error reset
  output logic flashErrorReset,
  output logic flashErrorFlag
);
  typedef struct packed {
    fks_dev_type state;
    logic storeWrite;
    logic storeErase;
    logic blockSel;
    logic readTimeSel;
    logic oneShot;
    logic holdValid;
    logic [ADDR_W-2:0] holdPair;
    logic [7:0] holdData;
    logic [ADDR_W-1:0] opAddr;
    logic [7:0] opData0;
    logic [7:0] opData1;
    logic [9:0] opLimit;
    logic [9:0] opIndex;
    logic [31:0] timer;
    logic rdPend;
    logic rdWait;
    logic [ADDR_W-1:0] rdAddr;
    logic [7:0] rdData;
    logic rdValid;
    logic [7:0] regRdData;
    logic xramWrite;
    logic [ADDR_W-1:0] xramAddr;
    logic [7:0] xramData;
    logic errReset;
    logic errFlag;
  } fks_dev_regs_type;

  fks_dev_regs_type r;
  fks_dev_regs_type next_r;
  logic [7:0] flashMem [FLASH_SIZE];
  logic [7:0] memReadValue;
  logic [1:0] keyCode;
  logic keyWrite;
  logic attempt;
  logic opDone;
  logic wrEn;
  logic wrErase;
  logic [ADDR_W-1:0] wrAddr;
  logic [7:0] wrData;

  // Legal user flash address
  function automatic logic addrLegal(input logic [ADDR_W-1:0] a);
    return (a < RESERVED_BASE) && (32'(a) < FLASH_SIZE);
  endfunction

  assign keyWrite = link.regWrite && (link.regAddr == REG_KEY);
  assign memReadValue = flashMem[r.rdAddr];

  fks_key_unlock keyUnlock (
    .clock(clock),
    .sys_rst(sys_rst),
    .clockEnable(clockEnable),
    .keyWrite(keyWrite),
    .keyData(link.regData),
    .attempt(attempt),
    .opDone(opDone),
    .keyCode(keyCode)
  );

  always_comb begin
    next_r = r;
    next_r.rdValid = 1'b0;
    next_r.xramWrite = 1'b0;
    next_r.errReset = 1'b0;
    attempt = 1'b0;
    opDone = 1'b0;
    wrEn = 1'b0;
    wrErase = 1'b0;
    wrAddr = r.opAddr + ADDR_W'(r.opIndex);
    wrData = (r.opIndex == 10'h0) ? r.opData0 : r.opData1;
    // Register read back
    case (link.regAddr)
      REG_KEY: next_r.regRdData = {6'h0, keyCode};
      REG_STORE_CTRL: next_r.regRdData = {6'h0, r.storeErase, r.storeWrite};
      REG_PREFETCH: next_r.regRdData = {7'h0, r.blockSel};
      default: next_r.regRdData = {r.oneShot, 2'h0, r.readTimeSel, 4'h0};
    endcase
    // Register writes
    if (link.regWrite) begin
      case (link.regAddr)
        REG_STORE_CTRL: begin
          next_r.storeWrite = link.regData[SWE_BIT];
          next_r.storeErase = link.regData[SEE_BIT];
        end
        REG_PREFETCH: next_r.blockSel = link.regData[BLOCK_SEL_BIT];
        REG_TIMING: begin
          next_r.readTimeSel = link.regData[READ_TIME_BIT];
          next_r.oneShot = link.regData[ONE_SHOT_BIT];
        end
        default: next_r.regRdData = next_r.regRdData;
      endcase
    end
    // Flash reads, one extra wait with the long read time
    if (r.rdPend) begin
      if (r.rdWait) begin
        next_r.rdWait = 1'b0;
      end else begin
        next_r.rdPend = 1'b0;
        next_r.rdValid = 1'b1;
        next_r.rdData = memReadValue;
      end
    end else if (link.rdReq && r.state == DV_IDLE) begin
      if (!addrLegal(link.memAddr)) begin
        next_r.errReset = 1'b1;
        next_r.errFlag = 1'b1;
      end else begin
        next_r.rdPend = 1'b1;
        next_r.rdWait = r.readTimeSel;
        next_r.rdAddr = link.memAddr;
      end
    end
    case (r.state)
      DV_IDLE: begin
        if (link.memWrite) begin
          if (!r.storeWrite) begin
            next_r.xramWrite = 1'b1;
            next_r.xramAddr = link.memAddr;
            next_r.xramData = link.memData;
          end else if (!addrLegal(link.memAddr)) begin
            next_r.errReset = 1'b1;
            next_r.errFlag = 1'b1;
          end else if (keyCode != KEY_UNLOCKED) begin
            attempt = 1'b1;
          end else if (r.storeErase) begin
            next_r.state = DV_ERASE;
            next_r.opAddr = (link.memAddr >> PAGE_SHIFT) << PAGE_SHIFT;
            next_r.opLimit = 10'(PAGE_BYTES);
            next_r.opIndex = 10'h0;
            next_r.timer = 32'h0;
          end else if (!r.blockSel) begin
            next_r.state = DV_PROGRAM;
            next_r.opAddr = link.memAddr;
            next_r.opData0 = link.memData;
            next_r.opLimit = 10'h1;
            next_r.opIndex = 10'h0;
            next_r.timer = 32'h0;
          end else if (!link.memAddr[0]) begin
            next_r.holdValid = 1'b1;
            next_r.holdPair = link.memAddr[ADDR_W-1:1];
            next_r.holdData = link.memData;
            opDone = 1'b1;
          end else begin
            next_r.state = DV_PROGRAM;
            next_r.opAddr = {link.memAddr[ADDR_W-1:1], 1'b0};
            next_r.opData0 = (r.holdValid && r.holdPair == link.memAddr[ADDR_W-1:1]) ?
                             r.holdData : ERASED_BYTE;
            next_r.opData1 = link.memData;
            next_r.opLimit = 10'h2;
            next_r.opIndex = 10'h0;
            next_r.timer = 32'h0;
            next_r.holdValid = 1'b0;
          end
        end
      end
      DV_PROGRAM, DV_ERASE: begin
        wrErase = (r.state == DV_ERASE);
        if (r.opIndex < r.opLimit) begin
          wrEn = 1'b1;
          next_r.opIndex = r.opIndex + 10'h1;
        end
        next_r.timer = r.timer + 32'h1;
        if (r.timer == 32'((wrErase ? ERASE_COUNT : PROGRAM_COUNT) - 1)) begin
          next_r.state = DV_IDLE;
          opDone = 1'b1;
        end
      end
      default: next_r.state = DV_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      r <= '0;
      r.state <= DV_IDLE;
      r.oneShot <= ONE_SHOT_RESET;
    end else if (clockEnable) begin
      r <= next_r;
    end
  end

  // Array update: erase writes all ones, program can only clear bits
  always_ff @(posedge clock) begin
    if (clockEnable && wrEn) begin
      flashMem[wrAddr] <= wrErase ? ERASED_BYTE : (flashMem[wrAddr] & wrData);
    end
  end

  assign link.stall = (r.state != DV_IDLE);
  assign link.regRdData = r.regRdData;
  assign link.rdData = r.rdData;
  assign link.rdValid = r.rdValid;
  assign xramWrite = r.xramWrite;
  assign xramAddr = r.xramAddr;
  assign xramData = r.xramData;
  assign flashErrorReset = r.errReset;
  assign flashErrorFlag = r.errFlag;
endmodule
`default_nettype wire

// *** fks_pkg.sv ***
// Shared constants and types for the flash key, write and erase sequencer
package fks_pkg;
  // Timing at the system clock
  localparam int CLOCK_MHZ = 100;
  localparam int WRITE_TIME_US = 70;
  localparam int ERASE_TIME_US = 20000;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLOCK_MHZ;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLOCK_MHZ;
  // Array geometry
  localparam int ADDR_W = 16;
  localparam int FLASH_BYTES = 65536;
  localparam int PAGE_BYTES = 512;
  localparam int PAGE_SHIFT = 9;
  localparam logic [15:0] RESERVED_BASE = 16'hfc00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Key codes and key register read codes
  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;
  localparam logic [1:0] KEY_LOCKED = 2'h0;
  localparam logic [1:0] KEY_HALF = 2'h1;
  localparam logic [1:0] KEY_UNLOCKED = 2'h2;
  localparam logic [1:0] KEY_DISABLED = 2'h3;
  // Device register select on the link
  localparam logic [1:0] REG_KEY = 2'h0;
  localparam logic [1:0] REG_STORE_CTRL = 2'h1;
  localparam logic [1:0] REG_PREFETCH = 2'h2;
  localparam logic [1:0] REG_TIMING = 2'h3;
  // Field positions and reset values
  localparam int SWE_BIT = 0;
  localparam int SEE_BIT = 1;
  localparam int BLOCK_SEL_BIT = 0;
  localparam int READ_TIME_BIT = 4;
  localparam int ONE_SHOT_BIT = 7;
  localparam logic ONE_SHOT_RESET = 1'b1;
  // Host command registers on Wishbone
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_ADDR = 8'h04;
  localparam logic [7:0] HOST_DATA = 8'h08;
  localparam logic [7:0] HOST_STATUS = 8'h0c;
  localparam logic [1:0] OP_REG_WRITE = 2'h0;
  localparam logic [1:0] OP_MEM_WRITE = 2'h1;
  localparam logic [1:0] OP_MEM_READ = 2'h2;
  localparam logic [1:0] OP_REG_READ = 2'h3;

  typedef enum logic [1:0] {KS_LOCKED, KS_HALF, KS_OPEN, KS_DEAD} fks_key_type;
  typedef enum logic [1:0] {DV_IDLE, DV_PROGRAM, DV_ERASE} fks_dev_type;
  typedef enum logic [1:0] {HS_IDLE, HS_REG1, HS_REG2, HS_READ} fks_host_type;
endpackage

// *** fks_link_if.sv ***
// Link between the processor core end and the flash sequencer end
`timescale 1ns/1ps
`default_nettype none
interface fks_link_if;
  import fks_pkg::*;
  logic regWrite;
  logic [1:0] regAddr;
  logic [7:0] regData;
  logic [7:0] regRdData;
  logic memWrite;
  logic rdReq;
  logic [ADDR_W-1:0] memAddr;
  logic [7:0] memData;
  logic [7:0] rdData;
  logic rdValid;
  logic stall;
  modport device (input regWrite, regAddr, regData, memWrite, rdReq, memAddr, memData,
                  output regRdData, rdData, rdValid, stall);
  modport host (output regWrite, regAddr, regData, memWrite, rdReq, memAddr, memData,
                input regRdData, rdData, rdValid, stall);
endinterface
`default_nettype wire

// *** fks_key_unlock.sv ***
// Two-code key unlock state for flash write and erase
`timescale 1ns/1ps
`default_nettype none
module fks_key_unlock import fks_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clockEnable,
  // Key writes and events
  input wire logic keyWrite,
  input wire logic [7:0] keyData,
  input wire logic attempt,
  input wire logic opDone,
  // State code
  output logic [1:0] keyCode
);
  typedef struct packed {
    fks_key_type state;
  } fks_key_regs_type;

  fks_key_regs_type r;
  fks_key_regs_type next_r;

  always_comb begin
    next_r = r;
    case (r.state)
      KS_DEAD: next_r.state = KS_DEAD;
      KS_LOCKED: begin
        if (attempt) begin
          next_r.state = KS_DEAD;
        end else if (keyWrite) begin
          next_r.state = (keyData == KEY_FIRST) ? KS_HALF : KS_DEAD;
        end
      end
      KS_HALF: begin
        if (attempt) begin
          next_r.state = KS_DEAD;
        end else if (keyWrite) begin
          next_r.state = (keyData == KEY_SECOND) ? KS_OPEN : KS_DEAD;
        end
      end
      KS_OPEN: begin
        if (keyWrite) begin
          next_r.state = KS_DEAD;
        end else if (opDone) begin
          next_r.state = KS_LOCKED;
        end
      end
      default: next_r.state = KS_DEAD;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      r <= '{state: KS_LOCKED};
    end else if (clockEnable) begin
      r <= next_r;
    end
  end

  always_comb begin
    case (r.state)
      KS_LOCKED: keyCode = KEY_LOCKED;
      KS_HALF: keyCode = KEY_HALF;
      KS_OPEN: keyCode = KEY_UNLOCKED;
      default: keyCode = KEY_DISABLED;
    endcase
  end
endmodule
`default_nettype wire

// *** fks_core_host.sv ***
// Core end: Wishbone command registers that drive the flash link
`timescale 1ns/1ps
`default_nettype none
module fks_core_host import fks_pkg::*; (
  // Clock, reset and enable
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clockEnable,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // Link to the flash end
  fks_link_if.host link
);
  typedef struct packed {
    fks_host_type state;
    logic ack;
    logic [31:0] datR;
    logic [1:0] op;
    logic pending;
    logic [15:0] addr;
    logic [7:0] data;
    logic [7:0] rdByte;
    logic regWrite;
    logic memWrite;
    logic rdReq;
  } fks_host_regs_type;

  fks_host_regs_type r;
  fks_host_regs_type next_r;
  logic access;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wr,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = wr[8*i +: 8];
      end
    end
    return res;
  endfunction

  assign access = wb_cyc && wb_stb && !r.ack;

  always_comb begin
    next_r = r;
    next_r.ack = access;
    next_r.regWrite = 1'b0;
    next_r.memWrite = 1'b0;
    next_r.rdReq = 1'b0;
    if (access) begin
      case (wb_adr)
        HOST_CMD: next_r.datR = {30'h0, r.op};
        HOST_ADDR: next_r.datR = {16'h0, r.addr};
        HOST_DATA: next_r.datR = {24'h0, r.data};
        HOST_STATUS: next_r.datR = {16'h0, r.rdByte, 6'h0, link.stall, r.pending};
        default: next_r.datR = 32'h0;
      endcase
      if (wb_we) begin
        case (wb_adr)
          HOST_CMD: begin
            if (!r.pending && wb_sel[0]) begin
              next_r.op = wb_dat_w[1:0];
              next_r.pending = 1'b1;
            end
          end
          HOST_ADDR: next_r.addr = 16'(laneMerge({16'h0, r.addr}, wb_dat_w, wb_sel));
          HOST_DATA: next_r.data = 8'(laneMerge({24'h0, r.data}, wb_dat_w, wb_sel));
          default: next_r.data = next_r.data;
        endcase
      end
    end
    case (r.state)
      HS_IDLE: begin
        if (r.pending && !link.stall) begin
          case (r.op)
            OP_REG_WRITE: begin
              next_r.regWrite = 1'b1;
              next_r.pending = 1'b0;
            end
            OP_MEM_WRITE: begin
              next_r.memWrite = 1'b1;
              next_r.pending = 1'b0;
            end
            OP_MEM_READ: begin
              next_r.rdReq = 1'b1;
              next_r.state = HS_READ;
            end
            default: next_r.state = HS_REG1;
          endcase
        end
      end
      HS_REG1: next_r.state = HS_REG2;
      HS_REG2: begin
        next_r.rdByte = link.regRdData;
        next_r.pending = 1'b0;
        next_r.state = HS_IDLE;
      end
      HS_READ: begin
        if (link.rdValid) begin
          next_r.rdByte = link.rdData;
          next_r.pending = 1'b0;
          next_r.state = HS_IDLE;
        end
      end
      default: next_r.state = HS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      r <= '0;
      r.state <= HS_IDLE;
    end else if (clockEnable) begin
      r <= next_r;
    end
  end

  assign wb_ack = r.ack;
  assign wb_dat_r = r.datR;
  assign link.regWrite = r.regWrite;
  assign link.memWrite = r.memWrite;
  assign link.rdReq = r.rdReq;
  assign link.regAddr = r.addr[1:0];
  assign link.regData = r.data;
  assign link.memAddr = r.addr;
  assign link.memData = r.data;
endmodule
`default_nettype wire

// *** fks_asserts.sv ***
// Concurrent checks on the link between the core end and the flash end
`timescale 1ns/1ps
`default_nettype none
module fks_link_asserts import fks_pkg::*; #(
  parameter int PROGRAM_COUNT = WRITE_CYCLES,
  parameter int ERASE_COUNT = ERASE_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Link signals
  input wire logic regWrite,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regData,
  input wire logic [7:0] regRdData,
  input wire logic memWrite,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic stall
);
  logic swe, see, blk, sawDead, relock, wasErase;
  logic [1:0] addrQ;
  int cnt;
  wire logic keyRd = addrQ == REG_KEY;
  // Shadow of the control bits and of the stall length
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      {swe, see, blk, sawDead, relock, wasErase} <= 6'h00;
      addrQ <= 2'h0;
      cnt <= 0;
    end else begin
      addrQ <= regAddr;
      if (regWrite && regAddr == REG_STORE_CTRL) begin
        swe <= regData[SWE_BIT];
        see <= regData[SEE_BIT];
      end
      if (regWrite && regAddr == REG_PREFETCH) blk <= regData[BLOCK_SEL_BIT];
      cnt <= stall ? cnt + 1 : 0;
      if (stall && cnt == 0) wasErase <= see;
      if (keyRd && regRdData[1:0] == KEY_DISABLED) sawDead <= 1'b1;
      if ((regWrite && regAddr == REG_KEY) || memWrite) relock <= 1'b0;
      else if (!stall && cnt != 0) relock <= 1'b1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_prog_end;
    !stall && cnt != 0 && !wasErase;
  endsequence
  sequence s_erase_end;
    !stall && cnt != 0 && wasErase;
  endsequence
  a_key_upper: assert property (keyRd |-> regRdData[7:2] == 6'h00)
    else $error("key read upper bits set");
  a_dead_sticky: assert property (keyRd && sawDead |-> regRdData[1:0] == KEY_DISABLED)
    else $error("disabled key state left");
  a_relock_after: assert property (keyRd && relock |-> regRdData[1:0] == KEY_LOCKED)
    else $error("key not locked after operation");
  a_stall_cause: assert property ($rose(stall) |-> $past(memWrite) && $past(swe))
    else $error("stall without flash write");
  a_stall_run: assert property ($rose(stall) |-> stall [*8])
    else $error("stall too short");
  a_plain_ram: assert property (memWrite && !swe && !stall |=> !stall)
    else $error("ram write stalled");
  a_even_hold: assert property (memWrite && swe && !see && blk && !memAddr[0] && !stall
    |=> !stall)
    else $error("even byte started a program");
  a_program_time: assert property (s_prog_end |-> cnt == PROGRAM_COUNT)
    else $error("program length wrong");
  a_erase_time: assert property (s_erase_end |-> cnt == ERASE_COUNT)
    else $error("erase length wrong");
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the core end and flash end joined by the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fks_pkg::*;
  localparam int PC = 20;
  localparam int EC = 600;
  logic clock, sysRst, wbCyc, wbStb, wbWe, wbAck, xramWrite, errRst, errFlag;
  logic [7:0] wbAdr, lf, hd;
  logic [31:0] wbDatW, wbDatR;
  logic [15:0] xramAddr;
  logic [7:0] xramData;
  int err_count, tests_run, cycles, errSeen, ks, ha;
  logic sw, se, bk, hv;
  bit [7:0] m [int];
  logic [23:0] xq [$];
  fks_link_if link();
  fks_core_host u_fks_core_host (.clock(clock), .sys_rst(sysRst), .clockEnable(1'b1),
    .wb_cyc(wbCyc), .wb_stb(wbStb), .wb_we(wbWe), .wb_adr(wbAdr), .wb_sel(4'hf),
    .wb_dat_w(wbDatW), .wb_dat_r(wbDatR), .wb_ack(wbAck), .link(link));
  fks_flash_device #(.PROGRAM_COUNT(PC), .ERASE_COUNT(EC)) u_fks_flash_device (
    .clock(clock), .sys_rst(sysRst), .clockEnable(1'b1), .link(link),
    .xramWrite(xramWrite), .xramAddr(xramAddr), .xramData(xramData),
    .flashErrorReset(errRst), .flashErrorFlag(errFlag));
  fks_link_asserts #(.PROGRAM_COUNT(PC), .ERASE_COUNT(EC)) u_fks_link_asserts (
    .clock(clock), .sys_rst(sysRst), .regWrite(link.regWrite), .regAddr(link.regAddr),
    .regData(link.regData), .regRdData(link.regRdData), .memWrite(link.memWrite),
    .memAddr(link.memAddr), .stall(link.stall));
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic finish_test();
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clock);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatW} <= {2'b11, we, a, d};
    do @(posedge clock); while (wbAck !== 1'b1);
    r = wbDatR;
    {wbCyc, wbStb} <= 2'b00;
  endtask
  task automatic op(input logic [1:0] c, input logic [15:0] a, input logic [7:0] d,
                    output logic [7:0] rb);
    logic [31:0] r;
    wb(1'b1, HOST_ADDR, {16'h0000, a}, r);
    wb(1'b1, HOST_DATA, {24'h000000, d}, r);
    wb(1'b1, HOST_CMD, {30'h0, c}, r);
    wb(1'b0, HOST_STATUS, 32'h0, r);
    do wb(1'b0, HOST_STATUS, 32'h0, r); while (r[1:0] !== 2'b00);
    rb = r[15:8];
  endtask
  task automatic rw(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] x;
    op(OP_REG_WRITE, {14'h0, a}, d, x);
    if (a == REG_KEY) ks = (ks == 0 && d == KEY_FIRST) ? 1 : (ks == 1 && d == KEY_SECOND) ? 2 : 3;
    if (a == REG_STORE_CTRL) {se, sw} = d[1:0];
    if (a == REG_PREFETCH) bk = d[BLOCK_SEL_BIT];
  endtask
  task automatic kr();
    logic [7:0] x;
    op(OP_REG_READ, {14'h0, REG_KEY}, 8'h00, x);
    chk("key state", x, ks);
  endtask
  task automatic keys();
    rw(REG_KEY, KEY_FIRST);
    kr();
    rw(REG_KEY, KEY_SECOND);
    kr();
  endtask
  task automatic mw(input logic [15:0] a, input logic [7:0] d);
    int n;
    logic [7:0] x;
    n = xq.size();
    op(OP_MEM_WRITE, a, d, x);
    if (!sw) begin
      chk("xram count", xq.size(), n + 1);
      chk("xram write", xq[$], {a, d});
    end else if (ks != 2) ks = 3;
    else begin
      ks = 0;
      if (se) for (int i = 0; i < PAGE_BYTES; i++) m[{a[15:9], 9'h000} + i] = ERASED_BYTE;
      else if (!bk) m[a] &= d;
      else if (!a[0]) {hv, ha, hd} = {1'b1, 32'(a), d};
      else begin
        if (hv && ha == a - 1) m[a - 1] &= hd;
        m[a] &= d;
        hv = 1'b0;
      end
    end
  endtask
  task automatic mr(input logic [15:0] a);
    logic [7:0] x;
    op(OP_MEM_READ, a, 8'h00, x);
    chk("flash byte", x, m[a]);
  endtask
  task automatic rst();
    sysRst <= 1'b1;
    repeat (12) @(posedge clock);
    sysRst <= 1'b0;
    {ks, sw, se, bk, hv} = '0;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (xramWrite === 1'b1) xq.push_back({xramAddr, xramData});
    if (errRst === 1'b1) errSeen++;
    if (cycles > 40000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    logic [7:0] x;
    logic [15:0] a;
    logic [7:0] bd [3];
    int e;
    bd = '{KEY_SECOND, KEY_FIRST, 8'h00};
    {sysRst, wbCyc, wbStb, wbWe, wbAdr, wbDatW} = {1'b1, 43'h0};
    {err_count, tests_run, cycles, errSeen} = '0;
    lf = 8'd23;
    rst();
    op(OP_REG_READ, {14'h0, REG_TIMING}, 8'h00, x);
    chk("timing reset", x, 8'h80);
    rw(REG_TIMING, 8'h90);
    kr();
    // Erase a page, then read its edges and random bytes
    lf = nx(lf);
    a = 16'h0400 + lf;
    keys();
    rw(REG_STORE_CTRL, 8'h02);
    rw(REG_STORE_CTRL, 8'h03);
    mw(a, lf);
    kr();
    mr(16'h0400);
    mr(16'h05ff);
    for (int i = 0; i < 4; i++) begin
      lf = nx(lf);
      mr({7'h02, lf, i[0]});
    end
    rw(REG_STORE_CTRL, 8'h02);
    rw(REG_STORE_CTRL, 8'h00);
    // Single-byte programs only clear bits
    rw(REG_STORE_CTRL, 8'h01);
    for (int i = 0; i < 2; i++) begin
      lf = nx(lf);
      keys();
      mw(a, lf);
      mr(a);
      kr();
    end
    // Pair writes with keys before each byte, and a lone odd byte
    rw(REG_PREFETCH, 8'h01);
    keys();
    mw(16'h0510, 8'h3c);
    kr();
    mr(16'h0510);
    keys();
    mw(16'h0511, 8'hc3);
    mr(16'h0510);
    mr(16'h0511);
    keys();
    mw(16'h0521, lf);
    mr(16'h0520);
    mr(16'h0521);
    rw(REG_PREFETCH, 8'h00);
    // Erase enable alone goes to ram and keeps the unlock
    keys();
    rw(REG_STORE_CTRL, 8'h02);
    mw(a, 8'h00);
    kr();
    rw(REG_STORE_CTRL, 8'h00);
    mw(16'h1234, lf);
    rw(REG_STORE_CTRL, 8'h01);
    mw(a ^ 16'h0001, 8'h0f);
    mr(a ^ 16'h0001);
    // Extra key while unlocked disables until reset
    keys();
    rw(REG_KEY, KEY_FIRST);
    kr();
    mw(a, 8'h00);
    mr(a);
    keys();
    // Wrong codes and order
    for (int i = 0; i < 3; i++) begin
      rst();
      if (i == 1) rw(REG_KEY, KEY_FIRST);
      rw(REG_KEY, bd[i]);
      keys();
    end
    // Write before unlock
    rst();
    rw(REG_STORE_CTRL, 8'h01);
    mw(a, 8'h00);
    mr(a);
    keys();
    // Reserved top area
    e = errSeen;
    lf = nx(lf);
    mw(RESERVED_BASE + lf, 8'h00);
    chk("error reset", errSeen, e + 1);
    chk("error flag", errFlag, 1'b1);
    rst();
    chk("error flag reset", errFlag, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
